// ### core/wac_prescale.sv
`timescale 1ns/1ps
`default_nettype none
`include "wac_params.svh"
// binary prescaler running on the oscillator itself
module wac_prescale #(
  parameter int W = `WAC_PRESC_W
) (
  input wire logic osc_clk,
  input wire logic srst,
  output logic [2:0] taps
);
  import wac_pkg::*;
  logic rst_meta; // reset crossing, first stage
  logic osc_rst; // reset in the oscillator domain
  logic [W-1:0] div; // free running divider

  if (W <= `WAC_TAP_1HZ) begin : g_bad_w
    $error("prescaler too narrow for the 1 hz tap");
  end

  // the reset comes from the system clock, so it is synchronised here
  always_ff @(posedge osc_clk) begin
    rst_meta <= srst;
    osc_rst <= rst_meta;
  end

  // divider: bit 1 is 8.192 khz, bit 2 is 4.096 khz, bit 14 is 1 hz
  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end

  // taps leave from flops so the far side sees clean levels
  always_ff @(posedge osc_clk) begin
    if (osc_rst) begin
      taps <= 3'h0;
    end else begin
      taps <= {div[`WAC_TAP_8K], div[`WAC_TAP_4K], div[`WAC_TAP_1HZ]};
    end
  end
endmodule // wac_prescale
`default_nettype wire

// ### core/wac_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two flop level synchroniser, one per bit
module wac_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  import wac_pkg::*;
  logic [W-1:0] meta; // first stage, read only by q

  if (W < 1) begin : g_bad_w
    $error("wac_sync needs at least one bit");
  end

  // nothing but the second stage may look at meta
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule // wac_sync
`default_nettype wire

// ### core/wac_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "wac_params.svh"
// Behaviour
// - countdown is 24 bits in three bytes
// - counter write loads count and seed
// - reads return a latched copy of count
// - disabled counter bytes are plain storage
// - all-zero write while enabled disables counter
// - seconds mode: flag, reload, restart
// - flag set at watchdog enable fires output
// - watchdog mode: 4096 hz, flag, stop
// - watchdog reset pulse blocks access, clears flag
// - irq pulse lasts 250ms, not truncated
// - write during pulse waits for pulse end
// - counter access before zero reloads and restarts
// - power fail holds reset, then 250ms more
// - stopped oscillator adds startup to hold
// - pin falling edge starts 250ms debounce
// - held button: wait release, 250ms more
// - osc_disable stops oscillator only on backup
// - square wave off on backup unless enabled
// - rate select picks four frequencies, resets 11
// - alarm irq starts only while enable set
// - enable, mode, steering reset to zero
// - alarm flag cleared by writing zero or at pulse end
// - charger needs key and valid settings
// - osc stop flag sticky until written zero
module wac_top #(
  parameter int SEC_TICKS = `WAC_SEC_TICKS,
  parameter int PULSE_TICKS = `WAC_PULSE_TICKS
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic osc_clk,
  input wire wac_pkg::wac_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic access_blocked,
  input wire logic power_fail,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic square_wave_pin_out,
  output logic square_wave_pin_oe,
  output logic osc_run_en,
  output wac_pkg::wac_charge_t charger
);
  import wac_pkg::*;

  localparam int SW = $clog2(SEC_TICKS);
  localparam int PW = $clog2(PULSE_TICKS);
  localparam logic [SW-1:0] SEC_LAST = SW'(SEC_TICKS - 1);
  localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_TICKS - 1);

  // timers need at least two ticks to have a distinct last value
  if (SEC_TICKS < 2 || PULSE_TICKS < 2) begin : g_bad_cnt
    $error("tick counts must be two or more");
  end

  // ---- clock crossing from the oscillator ----
  logic [2:0] osc_taps; // 8k, 4k, 1hz in the oscillator domain
  logic [3:0] wave_s; // 32k, 8k, 4k, 1hz seen by mclk
  logic [1:0] pin_s; // power fail and reset pin, synchronised
  logic tap4k_d; // previous 4k level for edge finding
  logic rpin_d; // previous reset pin level

  wac_prescale u_presc (
    .osc_clk(osc_clk),
    .srst(srst),
    .taps(osc_taps)
  );

  // slow square levels cross as plain levels; the oscillator
  // itself is sampled too, which is the 32 khz square wave
  wac_sync #(.W(4)) u_wave_sync (
    .clk(mclk),
    .rst(srst),
    .d({osc_clk, osc_taps}),
    .q(wave_s)
  );

  // pins are asynchronous to mclk
  wac_sync #(.W(2)) u_pin_sync (
    .clk(mclk),
    .rst(srst),
    .d({power_fail, reset_pin_in}),
    .q(pin_s)
  );

  wire pfail = pin_s[1]; // supply out of tolerance
  wire rpin = pin_s[0]; // reset pin level
  wire tick = wave_s[1] & ~tap4k_d; // one pulse per 1/4096 s
  wire rpin_fall = rpin_d & ~rpin; // button pressed

  // edge history, taken only from synchronised levels
  always_ff @(posedge mclk) begin
    if (srst) begin
      tap4k_d <= 1'b0;
      rpin_d <= 1'b1;
    end else begin
      tap4k_d <= wave_s[1];
      rpin_d <= rpin;
    end
  end

  // ---- seconds tick from the 4096 hz tick ----
  logic [SW-1:0] sec_div; // ticks within the current second
  wire sec_tick = tick & (sec_div == SEC_LAST);

  always_ff @(posedge mclk) begin
    if (srst) begin
      sec_div <= '0;
    end else if (sec_tick) begin
      sec_div <= '0;
    end else if (tick) begin
      sec_div <= sec_div + 1'b1;
    end
  end

  // ---- registers ----
  wac_ctrl_t ctrl; // control register
  logic [7:0] chg; // charger setup register
  logic [7:0] time_bytes [4]; // time count bytes, plain storage here
  logic [23:0] count; // live countdown
  logic [23:0] seed; // reload value
  logic [23:0] snap; // holding copy shifted out on reads
  logic cd_run; // counter armed with a nonzero value
  logic alarm_flag; // sticky alarm flag
  logic osc_stop_flag; // sticky oscillator stop flag
  logic irq_pulse; // 250ms watchdog pulse on the irq pin
  logic [PW-1:0] irq_tmr; // irq pulse length in ticks
  wac_rst_state_t rst_state; // reset sequencer state
  wac_rst_state_t next_rst_state;
  logic [PW-1:0] rst_tmr; // reset sequencer interval in ticks

  // accesses are dropped while any reset cycle runs
  wire acc_ok = ~access_blocked;
  wire wr = reg_req.wr & acc_ok;
  wire rd = reg_req.rd & acc_ok;
  wire [3:0] addr = reg_req.addr;
  wire sel_time = addr < `WAC_OFS_CD0;
  wire sel_cd = (addr >= `WAC_OFS_CD0) & (addr <= `WAC_OFS_CD2);
  wire sel_ctrl = addr == `WAC_OFS_CTRL;
  wire sel_stat = addr == `WAC_OFS_STAT;
  wire sel_chg = addr == `WAC_OFS_CHG;
  wire [1:0] cd_idx = 2'(addr - `WAC_OFS_CD0);
  wire [4:0] cd_lsb = {cd_idx, 3'h0};
  wire cd_wr = wr & sel_cd;
  wire cd_rd = rd & sel_cd;
  wire ctrl_wr = wr & sel_ctrl;
  wire stat_wr = wr & sel_stat;

  // control as it will be after this cycle's write
  wire wac_ctrl_t ctrl_new = ctrl_wr ? wac_ctrl_t'(reg_req.wdata) : ctrl;

  // seed with the written byte merged in
  logic [23:0] next_seed;
  always_comb begin
    next_seed = seed;
    if (cd_wr) begin
      next_seed[cd_lsb +: 8] = reg_req.wdata;
    end
  end

  // ---- countdown stepping ----
  wire wd_mode = ctrl.countdown_mode_select;
  wire pulse_busy = irq_pulse | (rst_state == RS_WDOG);
  wire cd_tick = wd_mode ? tick : sec_tick;
  // a pending pulse holds the counter so a fresh load waits for it
  wire cd_step = ctrl.countdown_enable & cd_run & ~pulse_busy & cd_tick;
  wire cd_expire = cd_step & (count == 24'h000001);
  wire wd_on = ctrl.countdown_enable & wd_mode;
  wire wd_turn_on = ctrl_new.countdown_enable & ctrl_new.countdown_mode_select & ~wd_on;
  // fire on expiry, or at once if the flag is already up
  wire wd_fire = (cd_expire & wd_mode) | (wd_turn_on & alarm_flag);
  wire fire_rst = wd_fire & ~ctrl_new.reset_steering;
  wire fire_irq = wd_fire & ctrl_new.reset_steering & ctrl_new.alarm_irq_enable;
  wire enable_rise = ctrl_wr & ctrl_new.countdown_enable & ~ctrl.countdown_enable;

  // counter, seed and run state
  always_ff @(posedge mclk) begin
    if (srst) begin
      count <= `WAC_CD_RST;
      seed <= `WAC_CD_RST;
      cd_run <= 1'b0;
    end else if (cd_wr) begin
      count <= next_seed;
      seed <= next_seed;
      cd_run <= |next_seed;
    end else if (cd_rd & cd_run & ctrl.countdown_enable) begin
      count <= seed;
    end else if (enable_rise) begin
      cd_run <= |count;
    end else if (cd_expire) begin
      count <= wd_mode ? 24'h000000 : seed;
      cd_run <= ~wd_mode;
    end else if (cd_step) begin
      count <= count - 24'h000001;
    end
  end

  // holding copy taken at each transfer start or stop, so a
  // multibyte read sees one coherent value while counting goes on
  always_ff @(posedge mclk) begin
    if (srst) begin
      snap <= `WAC_CD_RST;
    end else if (reg_req.frame) begin
      snap <= count;
    end
  end

  // control and charger storage
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl <= wac_ctrl_t'(`WAC_CTRL_RST);
      chg <= `WAC_CHG_RST;
    end else begin
      ctrl <= ctrl_new;
      if (wr & sel_chg) begin
        chg <= reg_req.wdata;
      end
    end
  end

  // time count bytes, one per lane
  for (genvar i = 0; i < 4; i++) begin : g_time
    always_ff @(posedge mclk) begin
      if (srst) begin
        time_bytes[i] <= `WAC_TIME_RST;
      end else if (wr & sel_time & (addr[1:0] == 2'(i))) begin
        time_bytes[i] <= reg_req.wdata;
      end
    end
  end

  // pulse completions clear the alarm flag
  wire irq_end = irq_pulse & tick & (irq_tmr == PULSE_LAST);
  wire rst_done = tick & (rst_tmr == PULSE_LAST);
  wire wdog_end = (rst_state == RS_WDOG) & rst_done;

  // alarm flag: hardware set beats any clear in the same cycle
  always_ff @(posedge mclk) begin
    if (srst) begin
      alarm_flag <= 1'b0;
    end else if (cd_expire) begin
      alarm_flag <= 1'b1;
    end else if (irq_end | wdog_end) begin
      alarm_flag <= 1'b0;
    end else if (stat_wr & ~reg_req.wdata[`WAC_STAT_AF_BIT]) begin
      alarm_flag <= 1'b0;
    end
  end

  // oscillator runs on primary supply whatever the bit says
  wire osc_on = ~pfail | ~ctrl.osc_disable;

  // stop flag is up after power-up and whenever the oscillator stops
  always_ff @(posedge mclk) begin
    if (srst) begin
      osc_stop_flag <= 1'b1;
    end else if (~osc_on) begin
      osc_stop_flag <= 1'b1;
    end else if (stat_wr & ~reg_req.wdata[`WAC_STAT_OSF_BIT]) begin
      osc_stop_flag <= 1'b0;
    end
  end

  // irq watchdog pulse; flag or enable writes cannot cut it short
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_pulse <= 1'b0;
      irq_tmr <= '0;
    end else if (fire_irq & ~irq_pulse) begin
      irq_pulse <= 1'b1;
      irq_tmr <= '0;
    end else if (irq_end) begin
      irq_pulse <= 1'b0;
    end else if (irq_pulse & tick) begin
      irq_tmr <= irq_tmr + 1'b1;
    end
  end

  // ---- reset sequencer ----
  // power fail wins over everything; button and watchdog only start
  // from idle, so one reset cycle never nests inside another
  always_comb begin
    next_rst_state = rst_state;
    unique case (rst_state)
      RS_IDLE: begin
        if (pfail) begin
          next_rst_state = RS_PFAIL;
        end else if (fire_rst) begin
          next_rst_state = RS_WDOG;
        end else if (rpin_fall) begin
          next_rst_state = RS_DEBOUNCE;
        end
      end
      RS_PFAIL: begin
        if (~pfail) begin
          next_rst_state = RS_HOLD;
        end
      end
      RS_HOLD: begin
        // ticks only arrive once the oscillator runs, so a stopped
        // oscillator stretches the hold by its startup time
        if (pfail) begin
          next_rst_state = RS_PFAIL;
        end else if (rst_done) begin
          next_rst_state = RS_IDLE;
        end
      end
      RS_DEBOUNCE: begin
        if (pfail) begin
          next_rst_state = RS_PFAIL;
        end else if (rst_done) begin
          next_rst_state = RS_WAIT_RISE;
        end
      end
      RS_WAIT_RISE: begin
        // pin released by us; a high level means the button is up
        if (pfail) begin
          next_rst_state = RS_PFAIL;
        end else if (rpin) begin
          next_rst_state = RS_HOLD;
        end
      end
      RS_WDOG: begin
        if (pfail) begin
          next_rst_state = RS_PFAIL;
        end else if (rst_done) begin
          next_rst_state = RS_IDLE;
        end
      end
    endcase
  end

  wire drive_next = (next_rst_state != RS_IDLE) & (next_rst_state != RS_WAIT_RISE);

  // state and interval timer, timer restarts on every change
  always_ff @(posedge mclk) begin
    if (srst) begin
      rst_state <= RS_HOLD;
      rst_tmr <= '0;
    end else begin
      rst_state <= next_rst_state;
      if (next_rst_state != rst_state) begin
        rst_tmr <= '0;
      end else if (tick) begin
        rst_tmr <= rst_tmr + 1'b1;
      end
    end
  end

  // ---- outputs, all from flops ----
  wire wave = wave_s[{ctrl.rate_select_hi, ctrl.rate_select_lo}];
  wire sq_on = ~pfail | ctrl.backup_square_wave_enable;
  // latched alarm only in seconds mode; watchdog mode uses the pulse
  wire irq_level = irq_pulse | (~wd_mode & ctrl.alarm_irq_enable & alarm_flag);
  wire chg_diode_ok = (chg[3:2] == `WAC_CHG_NO_DIODE) | (chg[3:2] == `WAC_CHG_ONE_DIODE);
  wire chg_on = (chg[7:4] == `WAC_CHG_KEY) & chg_diode_ok & (chg[1:0] != `WAC_CHG_NO_RES);
  wire [7:0] stat_rd = {osc_stop_flag, 6'h00, alarm_flag};
  wire [7:0] rd_mux = sel_time ? time_bytes[addr[1:0]] :
                      sel_cd ? snap[cd_lsb +: 8] :
                      sel_ctrl ? ctrl :
                      sel_stat ? stat_rd :
                      sel_chg ? chg : 8'h00;

  // open-drain pins only ever pull low; the enable carries the level
  always_ff @(posedge mclk) begin
    if (srst) begin
      reset_pin_out <= 1'b0;
      irq_pin_out <= 1'b0;
      square_wave_pin_out <= 1'b0;
      reset_pin_oe <= 1'b1;
      access_blocked <= 1'b1;
      irq_pin_oe <= 1'b0;
      square_wave_pin_oe <= 1'b0;
      osc_run_en <= 1'b1;
      charger <= '0;
      reg_rdata <= 8'h00;
    end else begin
      reset_pin_oe <= drive_next;
      access_blocked <= next_rst_state != RS_IDLE;
      irq_pin_oe <= irq_level;
      square_wave_pin_oe <= sq_on & ~wave;
      osc_run_en <= osc_on;
      charger <= '{on: chg_on, diode: chg[3], res: chg[1:0]};
      if (rd) begin
        reg_rdata <= rd_mux;
      end
    end
  end
endmodule // wac_top
`default_nettype wire

// ### inc/wac_params.svh
`ifndef WAC_PARAMS_SVH
`define WAC_PARAMS_SVH
// register offsets on the access port
`define WAC_OFS_TIME0 4'h0
`define WAC_OFS_CD0 4'h4
`define WAC_OFS_CD2 4'h6
`define WAC_OFS_CTRL 4'h7
`define WAC_OFS_STAT 4'h8
`define WAC_OFS_CHG 4'h9
// reset values
`define WAC_CTRL_RST 8'h06
`define WAC_CHG_RST 8'h00
`define WAC_CD_RST 24'h000000
`define WAC_TIME_RST 8'h00
// status field positions
`define WAC_STAT_OSF_BIT 7
`define WAC_STAT_AF_BIT 0
// charger key and diode codes
`define WAC_CHG_KEY 4'ha
`define WAC_CHG_NO_DIODE 2'h1
`define WAC_CHG_ONE_DIODE 2'h2
`define WAC_CHG_NO_RES 2'h0
// timing, all derived from the 32.768 khz oscillator
`define WAC_OSC_HZ 32768
`define WAC_TICK_HZ 4096
`define WAC_PULSE_MS 250
`define WAC_SEC_TICKS (`WAC_TICK_HZ)
`define WAC_PULSE_TICKS (`WAC_PULSE_MS * `WAC_TICK_HZ / 1000)
// prescaler width and taps
`define WAC_PRESC_W 15
`define WAC_TAP_8K 1
`define WAC_TAP_4K 2
`define WAC_TAP_1HZ 14
`endif

// ### inc/wac_pkg.sv
`default_nettype none
package wac_pkg;
  // control register, bit 7 down to bit 0
  typedef struct packed {
    logic osc_disable;
    logic countdown_enable;
    logic countdown_mode_select;
    logic backup_square_wave_enable;
    logic reset_steering;
    logic rate_select_hi;
    logic rate_select_lo;
    logic alarm_irq_enable;
  } wac_ctrl_t;
  // one register access from the serial engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic frame;
    logic [3:0] addr;
    logic [7:0] wdata;
  } wac_reg_req_t;
  // trickle charger setting toward the analog switch
  typedef struct packed {
    logic on;
    logic diode;
    logic [1:0] res;
  } wac_charge_t;
  // reset sequencer states
  typedef enum logic [2:0] {
    RS_IDLE,
    RS_PFAIL,
    RS_HOLD,
    RS_DEBOUNCE,
    RS_WAIT_RISE,
    RS_WDOG
  } wac_rst_state_t;
endpackage
`default_nettype wire

// ### verification/wac_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// register master and reset wire, driven on falling mclk
module wac_host_model (
  input wire logic mclk,
  input wire logic reset_pin_oe,
  input wire logic [7:0] reg_rdata,
  output var wac_pkg::wac_reg_req_t reg_req,
  output logic reset_pin_in
);
  import wac_pkg::*;
  logic button; // pushbutton pulls the wire low
  // pulled-up wire, low while anyone pulls
  assign reset_pin_in = !(reset_pin_oe === 1'b1 || button);
  initial begin
    reg_req = '0;
    button = 1'b0;
  end
  // one strobe over one edge; k is {wr, rd, frame}
  task automatic xfer(input logic [2:0] k, input logic [3:0] a, input logic [7:0] d,
      output logic [7:0] q);
    @(negedge mclk);
    reg_req = {k, a, d};
    @(negedge mclk);
    // released lines show the inverse, not a stale copy
    reg_req = {3'b000, ~a, ~d};
    q = reg_rdata;
  endtask
  // button level
  task automatic push(input logic v);
    @(negedge mclk);
    button = v;
  endtask
endmodule // wac_host_model
`default_nettype wire

// ### verification/wac_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the watchdog block
module wac_top_properties (
  input wire logic mclk,
  input wire logic srst,
  input wire wac_pkg::wac_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic access_blocked,
  input wire logic power_fail,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic irq_pin_out,
  input wire logic square_wave_pin_out,
  input wire wac_pkg::wac_charge_t charger
);
  import wac_pkg::*;
  // accepted read, any charger write
  wire logic take_rd = reg_req.rd && !access_blocked;
  wire logic chg_wr = reg_req.wr && reg_req.addr == 4'h9;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_open_drain: assert property (
    !reset_pin_out && !irq_pin_out && !square_wave_pin_out)
    else $error("open drain driven high");
  a_powerup_hold: assert property (
    $fell(srst) |-> reset_pin_oe && access_blocked)
    else $error("no hold after reset release");
  a_pfail_holds: assert property (
    power_fail [*4] |-> reset_pin_oe && access_blocked)
    else $error("power fail not holding reset");
  a_reset_width: assert property (
    $rose(reset_pin_oe) |-> reset_pin_oe [*8])
    else $error("reset pulse too short");
  a_rise_blocks: assert property (
    $rose(reset_pin_oe) |-> ##[0:2] access_blocked)
    else $error("reset pulse without blocking");
  a_rdata_holds: assert property (
    $changed(reg_rdata) |-> $past(take_rd))
    else $error("read data moved without a read");
  a_key_refused: assert property (
    chg_wr && !access_blocked && reg_req.wdata[7:4] != 4'ha |=> ##[0:1] !charger.on)
    else $error("charger on with wrong key");
  a_charger_res: assert property (
    charger.on |-> charger.res != 2'h0)
    else $error("charger on without resistor");
  a_blocked_frozen: assert property (
    chg_wr && access_blocked |=> $stable(charger))
    else $error("write taken while blocked");
endmodule // wac_top_properties
bind wac_top wac_top_properties i_props (
  .mclk(mclk), .srst(srst), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .access_blocked(access_blocked), .power_fail(power_fail), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .irq_pin_out(irq_pin_out),
  .square_wave_pin_out(square_wave_pin_out), .charger(charger)
);
`default_nettype wire

// ### verification/watchdog_alarm_reset_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the watchdog block
module watchdog_alarm_reset_control_tb_top;
  import wac_pkg::*;
  localparam int SEC_T = 8; // shortened seconds count
  localparam int PULSE_T = 4; // shortened pulse length
  localparam int TK = 52; // mclk cycles per tick, rounded up
  localparam int LIMIT = 40000; // run ceiling in cycles
  logic mclk, srst, osc_clk, power_fail, reset_pin_in, sq_last;
  wac_reg_req_t reg_req;
  logic [7:0] reg_rdata, q, v;
  logic [7:0] mem [7]; // storage test bytes
  logic [7:0] corner [4] = '{8'ha5, 8'ha9, 8'ha4, 8'hac}; // charger edge cases
  logic access_blocked, reset_pin_out, reset_pin_oe, irq_pin_out, irq_pin_oe;
  logic square_wave_pin_out, square_wave_pin_oe, osc_run_en;
  wac_charge_t charger;
  int bad_count, checks_done, cyc, t0, n;
  wac_top #(.SEC_TICKS(SEC_T), .PULSE_TICKS(PULSE_T)) i_dut (
    .mclk(mclk), .srst(srst), .osc_clk(osc_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .access_blocked(access_blocked), .power_fail(power_fail), .reset_pin_in(reset_pin_in),
    .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe), .square_wave_pin_out(square_wave_pin_out),
    .square_wave_pin_oe(square_wave_pin_oe), .osc_run_en(osc_run_en), .charger(charger)
  );
  wac_host_model i_host (.mclk(mclk), .reset_pin_oe(reset_pin_oe), .reg_rdata(reg_rdata),
    .reg_req(reg_req), .reset_pin_in(reset_pin_in));
  // system clock, 5 ns period
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // oscillator, own phase, stops when the device stops it
  initial begin
    osc_clk = 1'b0;
    #3.7;
    forever #16 if (osc_run_en === 1'b1) osc_clk = ~osc_clk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count = bad_count + 1;
      print_verdict();
    end
  end
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_rng(input string s, input int lo, input int hi, input int g);
    checks_done++;
    if (g < lo || g > hi) begin
      bad_count++;
      $display("mismatch %s expected %0d..%0d seen %0d", s, lo, hi, g);
    end
  endtask
  // 0 reset pin, 1 irq pin, 2 access blocked
  function automatic logic pin(input int w);
    return w == 0 ? reset_pin_oe : w == 1 ? irq_pin_oe : access_blocked;
  endfunction
  // bounded wait, t counts cycles
  task automatic wait_pin(input int w, input logic lv, input int lim, output int t);
    t = 0;
    while (pin(w) !== lv && t < lim) begin
      @(negedge mclk);
      t++;
    end
    chk8("pin level", {7'h0, lv}, {7'h0, pin(w)});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    i_host.xfer(3'b100, a, d, q);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string s);
    i_host.xfer(3'b010, a, 8'h00, q);
    chk8(s, e, q);
  endtask
  // count and seed = c
  task automatic load_cnt(input logic [7:0] c);
    for (int a = 4; a < 7; a++) wr(a[3:0], a == 4 ? c : 8'h00);
  endtask
  task automatic idle(input int k);
    repeat (k) @(negedge mclk);
  endtask
  function automatic logic [7:0] chg_on(input logic [7:0] d);
    return {4'h0, d[7:4] == 4'ha && (d[3:2] == 2'h1 || d[3:2] == 2'h2) && d[1:0] != 2'h0,
      d[3], d[1:0]};
  endfunction
  // oe rises in 1024 cycles; 1 hz shows none
  function automatic int sq_rises(input int rs);
    return rs == 0 ? 0 : 5120 / (32 * (rs == 3 ? 1 : rs == 2 ? 4 : 8));
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    srst = 1'b1;
    power_fail = 1'b0;
    cyc = 0;
    bad_count = 0;
    checks_done = 0;
    n = $urandom(36954);
    // long enough for the oscillator side to see reset
    idle(24);
    srst = 1'b0;
    wait_pin(2, 1'b0, 12 * TK, t0);
    rd_chk(4'h7, 8'h06, "control");
    rd_chk(4'h8, 8'h80, "status");
    rd_chk(4'h9, 8'h00, "charger_setup");
    wr(4'hc, 8'h5a);
    rd_chk(4'hc, 8'h00, "unmapped");
    wr(4'h8, 8'h01);
    rd_chk(4'h8, 8'h00, "status");
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      v = i < 4 ? corner[i] : 8'($urandom);
      wr(4'h9, v);
      idle(2);
      chk8("charger", chg_on(v), {4'h0, charger});
      rd_chk(4'h9, v, "charger_setup");
    end
    $display("test charger done");
    for (int i = 0; i < 3; i++) begin
      for (int a = 0; a < 7; a++) mem[a] = 8'($urandom);
      for (int a = 0; a < 7; a++) wr(a[3:0], mem[a]);
      i_host.xfer(3'b001, 4'h0, 8'h00, q);
      for (int a = 0; a < 7; a++) rd_chk(a[3:0], mem[a], "stored byte");
    end
    $display("test storage done");
    load_cnt(8'h04);
    wr(4'h7, 8'h66);
    for (int i = 0; i < 6; i++) begin
      idle(2 * TK);
      i_host.xfer(3'b010, 4'h4, 8'h00, q);
      chk8("reset pin", 8'h00, {7'h0, reset_pin_oe});
    end
    wait_pin(0, 1'b1, 6 * TK, t0);
    chk_rng("expiry", 3 * 51 - 4, 4 * TK + 6, t0);
    wait_pin(2, 1'b1, 4, n);
    wait_pin(0, 1'b0, (PULSE_T + 2) * TK, t0);
    chk_rng("reset pulse", (PULSE_T - 1) * 51, (PULSE_T + 1) * TK, t0);
    wait_pin(2, 1'b0, 8, n);
    rd_chk(4'h8, 8'h00, "status");
    idle(6 * TK);
    chk8("stopped", 8'h00, {7'h0, reset_pin_oe});
    wr(4'h7, 8'h06);
    $display("test watchdog reset done");
    load_cnt(8'h02);
    wr(4'h7, 8'h6f);
    wait_pin(1, 1'b1, 4 * TK, t0);
    wr(4'h8, 8'h00);
    load_cnt(8'h05);
    wait_pin(1, 1'b0, (PULSE_T + 2) * TK, t0);
    chk_rng("irq pulse", (PULSE_T - 1) * 51 - 8, (PULSE_T + 1) * TK, t0);
    rd_chk(4'h8, 8'h00, "status");
    wait_pin(1, 1'b1, 8 * TK, t0);
    chk_rng("restart", 4 * 51 - 4, 5 * TK + 8, t0);
    wr(4'h7, 8'h06);
    wait_pin(1, 1'b0, (PULSE_T + 2) * TK, n);
    $display("test watchdog irq done");
    load_cnt(8'h01);
    wr(4'h7, 8'h46);
    idle((SEC_T + 2) * TK);
    chk8("irq masked", 8'h00, {7'h0, irq_pin_oe});
    rd_chk(4'h8, 8'h01, "status");
    wr(4'h8, 8'h01);
    rd_chk(4'h8, 8'h01, "status");
    wr(4'h7, 8'h47);
    wait_pin(1, 1'b1, 4, n);
    wr(4'h8, 8'h00);
    wait_pin(1, 1'b0, 4, n);
    idle((SEC_T + 2) * TK);
    rd_chk(4'h8, 8'h01, "status");
    load_cnt(8'h40);
    wr(4'h7, 8'h66);
    wait_pin(0, 1'b1, 8, n);
    wait_pin(0, 1'b0, (PULSE_T + 2) * TK, n);
    wait_pin(2, 1'b0, 8, n);
    wr(4'h7, 8'h06);
    wr(4'h8, 8'h00);
    wr(4'h7, 8'h46);
    load_cnt(8'h00);
    wr(4'h8, 8'h00);
    idle((SEC_T + 2) * TK);
    rd_chk(4'h8, 8'h00, "status");
    wr(4'h7, 8'h06);
    $display("test seconds alarm done");
    i_host.push(1'b1);
    wait_pin(0, 1'b1, 6, n);
    wait_pin(2, 1'b1, 4, n);
    wait_pin(0, 1'b0, (PULSE_T + 2) * TK, t0);
    chk_rng("debounce", (PULSE_T - 1) * 51, (PULSE_T + 1) * TK, t0);
    idle(2 * TK);
    chk8("held button", 8'h00, {7'h0, reset_pin_oe});
    i_host.push(1'b0);
    wait_pin(0, 1'b1, 6, n);
    wait_pin(0, 1'b0, (PULSE_T + 2) * TK, t0);
    chk_rng("release hold", (PULSE_T - 1) * 51, (PULSE_T + 1) * TK, t0);
    wait_pin(2, 1'b0, 8, n);
    $display("test pushbutton done");
    wr(4'h7, 8'h86);
    idle(2);
    chk8("osc run", 8'h01, {7'h0, osc_run_en});
    power_fail = 1'b1;
    idle(8);
    chk8("reset pin", 8'h01, {7'h0, reset_pin_oe});
    chk8("osc run", 8'h00, {7'h0, osc_run_en});
    for (int i = 0; i < 4; i++) begin
      idle(TK);
      chk8("square wave", 8'h00, {7'h0, square_wave_pin_oe});
    end
    wr(4'h9, 8'ha5);
    power_fail = 1'b0;
    wait_pin(0, 1'b0, (PULSE_T + 4) * TK, t0);
    chk_rng("recovery", (PULSE_T - 1) * 51, (PULSE_T + 2) * TK + 10, t0);
    wait_pin(2, 1'b0, 8, n);
    rd_chk(4'h8, 8'h80, "status");
    $display("test power fail done");
    for (int rs = 0; rs < 4; rs++) begin
      wr(4'h7, rs[7:0] << 1);
      idle(8);
      n = 0;
      sq_last = square_wave_pin_oe;
      repeat (1024) begin
        @(negedge mclk);
        n += int'(square_wave_pin_oe && !sq_last);
        sq_last = square_wave_pin_oe;
      end
      chk_rng("square rises", sq_rises(rs) - 2, sq_rises(rs) + 2, n);
    end
    $display("test square wave done");
    print_verdict();
  end
endmodule // watchdog_alarm_reset_control_tb_top
`default_nettype wire
